// >>> hdl/abx_exit_stop.sv
// address bounds check, queue substitution and exit-mode stop sequence
`include "abx_defs.svh"

module abx_exit_stop #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rstn_in,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // staging register side
  input  wire logic              stg_valid_in,
  input  wire logic [ADDR_W-1:0] stg_addr_in,
  input  wire logic [1:0]        stg_kind_in,
  input  wire logic [2:0]        stg_reg_in,
  input  wire logic [ADDR_W-1:0] prog_addr_in,
  input  wire logic              exch_in,
  output logic                   stg_ready_out,
  // queue entry register
  output logic                   q_valid_out,
  output logic [ADDR_W-1:0]      q_addr_out,
  output logic [5:0]             q_tag_out,
  output logic [59:0]            q_data_out,
  input  wire logic              q_ready_in,
  // tag timing chain
  input  wire logic              mem_accept_in,
  input  wire logic [5:0]        acc_tag_in,
  // issue control
  input  wire logic              error_sync_in,
  input  wire logic              inch_in,
  input  wire logic              scoreboard_issue_in,
  input  wire logic [5:0]        fcode_in,
  output logic                   proceed_out,
  output logic                   fetch_flag_out,
  output logic                   stop_out,
  output logic                   p_clear_out,
  output logic                   go_branch_out,
  // floating point units
  input  wire logic              fp_valid_in,
  input  wire logic [11:0]       fp_exp_in,
  input  wire logic              fp_indef_in
);
  localparam int DLY_CYC = (`ABX_DELAY_NS * `ABX_CLK_MHZ) / 1000;
  localparam int GAP_CYC = (`ABX_GAP_NS * `ABX_CLK_MHZ) / 1000;

  // status and record fields leave room for 30 address bits at most
  if (ADDR_W > 30 || ADDR_W < 3) begin : g_bad_width
    $error("ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [ADDR_W-1:0]       limit_q;
  logic [ADDR_W-1:0]       base_q;
  logic [2:0]              exitsel_q;
  logic                    ack_q;
  logic [31:0]             rdata_q;
  logic                    oob_q;
  logic                    oob_used_q;
  logic                    error_q;
  logic                    stop_q;
  logic                    seq_q;
  logic                    exit_q;
  logic                    fetch_q;
  logic                    proceed_q;
  logic                    pclr_q;
  logic [2:0]              cause_q;
  logic [6:0]              cnt_q;
  abx_pkg::abx_state_t     state_q;
  logic                    qv_q;
  logic [ADDR_W-1:0]       qa_q;
  logic [5:0]              qt_q;
  logic [59:0]             qd_q;

  logic                    beyond;
  logic                    slot_free;
  logic                    seq_req;
  logic                    stg_take;
  logic                    seq_take;
  logic                    wr_en;
  logic                    inf_evt;
  logic                    indef_evt;
  logic                    oob_err;
  logic                    err_set;
  logic                    acc_evt;
  logic                    halt_hit;
  logic                    nstop_hit;
  logic                    dly_done;
  logic                    gap_done;
  logic [ADDR_W-1:0]       sub_addr;
  logic [5:0]              sub_tag;
  logic [59:0]             exit_rec;

  abx_cmp_if #(.ADDR_W(ADDR_W)) cmp_c ();

  ////////////////////////////////////////////////////////////////////////
  // bounds comparator
  assign cmp_c.addr  = stg_addr_in;
  assign cmp_c.limit = limit_q;
  assign beyond      = cmp_c.beyond;

  abx_bound_cmp #(.ADDR_W(ADDR_W)) u_cmp (
    .c (cmp_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle per access
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out    = rdata_q;
  assign wr_en               = avs_write_in & ack_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
    end
  end

  // read data latched while waitrequest is high
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      unique case (avs_address_in)
        `ABX_OFS_LIMIT:   rdata_q <= 32'(limit_q);
        `ABX_OFS_BASE:    rdata_q <= 32'(base_q);
        `ABX_OFS_EXITSEL: rdata_q <= 32'(exitsel_q);
        `ABX_OFS_STATUS:  rdata_q <= {20'h0_0000, cause_q, 3'(state_q), fetch_q, exit_q,
                                      seq_q, stop_q, error_q, oob_q};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // software-written configuration
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      limit_q   <= '0;
      base_q    <= '0;
      exitsel_q <= 3'h0;
    end else if (wr_en) begin
      if (avs_address_in == `ABX_OFS_LIMIT)
        limit_q <= avs_writedata_in[ADDR_W-1:0];
      if (avs_address_in == `ABX_OFS_BASE)
        base_q <= avs_writedata_in[ADDR_W-1:0];
      if (avs_address_in == `ABX_OFS_EXITSEL)
        exitsel_q <= avs_writedata_in[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // queue slot arbitration, sequence first
  assign slot_free     = ~qv_q | q_ready_in;
  assign seq_req       = (state_q == abx_pkg::ABX_ST_WRITE) | (state_q == abx_pkg::ABX_ST_FETCH);
  assign stg_ready_out = slot_free & ~seq_req;
  assign stg_take      = stg_valid_in & stg_ready_out;
  assign seq_take      = seq_req & slot_free;

  // substituted address and tag for the staging request
  always_comb begin
    sub_addr = ADDR_W'(stg_addr_in + base_q);
    sub_tag  = `ABX_TAG_RNI;
    unique case (stg_kind_in)
      abx_pkg::ABX_K_READ:  sub_tag = `ABX_TAG_READ | 6'(stg_reg_in);
      abx_pkg::ABX_K_STORE: sub_tag = `ABX_TAG_STORE | 6'(stg_reg_in);
      default:              sub_tag = `ABX_TAG_RNI;
    endcase
    if (beyond) begin
      sub_addr = '0;
      sub_tag[`ABX_TAG_WBIT] = 1'b0;
      if (stg_kind_in == abx_pkg::ABX_K_FETCH)
        sub_tag = `ABX_TAG_RNI;
      if (stg_kind_in == abx_pkg::ABX_K_READ)
        sub_tag = `ABX_TAG_RNI;
      if (stg_kind_in == abx_pkg::ABX_K_STORE)
        sub_tag = `ABX_TAG_READ | 6'(stg_reg_in);
    end
  end

  // exit record: stop code, causes, address
  assign exit_rec = {6'h00, 3'h0, cause_q, 18'(prog_addr_in), 30'h0000_0000};

  // queue entry register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      qv_q <= 1'b0;
      qa_q <= '0;
      qt_q <= 6'h00;
      qd_q <= '0;
    end else if (seq_take && state_q == abx_pkg::ABX_ST_WRITE) begin
      qv_q <= 1'b1;
      qa_q <= base_q;
      qt_q <= `ABX_TAG_XWRITE;
      qd_q <= exit_rec;
    end else if (seq_take) begin
      qv_q <= 1'b1;
      qa_q <= base_q;
      qt_q <= `ABX_TAG_RNI;
      qd_q <= '0;
    end else if (stg_take) begin
      qv_q <= 1'b1;
      qa_q <= sub_addr;
      qt_q <= sub_tag;
      qd_q <= '0;
    end else if (q_ready_in) begin
      qv_q <= 1'b0;
    end
  end

  assign q_valid_out = qv_q;
  assign q_addr_out  = qa_q;
  assign q_tag_out   = qt_q;
  assign q_data_out  = qd_q;

  ////////////////////////////////////////////////////////////////////////
  // error sources
  // exponent above 3777 or indefinite
  assign inf_evt   = fp_valid_in & (fp_exp_in > `ABX_EXP_MAX) & exitsel_q[`ABX_EM_INF];
  assign indef_evt = fp_valid_in & fp_indef_in & exitsel_q[`ABX_EM_INDEF];
  // out of bounds with exit bit0 and sync stage
  assign oob_err   = oob_q & exitsel_q[`ABX_EM_OOB] & error_sync_in & ~oob_used_q;
  assign err_set   = oob_err | inf_evt | indef_evt;

  // out-of-bounds flag, set wins over clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      oob_q <= 1'b0;
    end else if (stg_take && beyond && !exch_in) begin
      oob_q <= 1'b1;
    end else if (wr_en && avs_address_in == `ABX_OFS_CLEAR && avs_writedata_in[`ABX_CLR_OOB]) begin
      oob_q <= 1'b0;
    end
  end

  // a standing oob flag raises the error only once
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      oob_used_q <= 1'b0;
    end else begin
      oob_used_q <= oob_q & (oob_used_q | oob_err);
    end
  end

  // error flag, cleared once sequencing is set
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      error_q <= 1'b0;
    end else if (err_set) begin
      error_q <= 1'b1;
    end else if (seq_q) begin
      error_q <= 1'b0;
    end
  end

  // exit cause bits kept for the record
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cause_q <= 3'h0;
    end else if (err_set) begin
      cause_q <= cause_q | {indef_evt, inf_evt, oob_err};
    end else if (halt_hit) begin
      cause_q <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stop sequence
  assign dly_done  = cnt_q == 7'(DLY_CYC - 1);
  assign gap_done  = cnt_q == 7'(GAP_CYC - 1);
  assign halt_hit  = state_q == abx_pkg::ABX_ST_HALT && scoreboard_issue_in && fcode_in[5:3] == 3'h0;
  assign nstop_hit = scoreboard_issue_in && fcode_in == 6'h00;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= abx_pkg::ABX_ST_IDLE;
      cnt_q   <= 7'h00;
      seq_q   <= 1'b0;
    end else begin
      unique case (state_q)
        abx_pkg::ABX_ST_IDLE: begin
          cnt_q <= 7'h00;
          if (error_q)
            state_q <= abx_pkg::ABX_ST_DELAY;
        end
        abx_pkg::ABX_ST_DELAY: begin
          // count, then wait for inch clear
          if (!dly_done)
            cnt_q <= cnt_q + 7'h01;
          else if (!inch_in) begin
            seq_q   <= 1'b1;
            cnt_q   <= 7'h00;
            state_q <= abx_pkg::ABX_ST_WRITE;
          end
        end
        abx_pkg::ABX_ST_WRITE: begin
          cnt_q <= 7'h00;
          if (seq_take)
            state_q <= abx_pkg::ABX_ST_GAP;
        end
        abx_pkg::ABX_ST_GAP: begin
          // spacing after the tag 50 request
          if (gap_done)
            state_q <= abx_pkg::ABX_ST_FETCH;
          else
            cnt_q <= cnt_q + 7'h01;
        end
        abx_pkg::ABX_ST_FETCH: begin
          if (seq_take)
            state_q <= abx_pkg::ABX_ST_HALT;
        end
        abx_pkg::ABX_ST_HALT: begin
          if (halt_hit) begin
            seq_q   <= 1'b0;
            state_q <= abx_pkg::ABX_ST_IDLE;
          end
        end
        default: begin
          state_q <= abx_pkg::ABX_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      exit_q <= 1'b0;
    end else if (seq_take && state_q == abx_pkg::ABX_ST_WRITE) begin
      exit_q <= 1'b1;
    end else if (halt_hit) begin
      exit_q <= 1'b0;
    end
  end

  assign go_branch_out = exit_q;

  ////////////////////////////////////////////////////////////////////////
  // fetch flag and proceed on tag 10 accept
  // accept with exit selected
  assign acc_evt = mem_accept_in & (acc_tag_in == `ABX_TAG_RNI) & exitsel_q[`ABX_EM_OOB];

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetch_q   <= 1'b0;
      proceed_q <= 1'b0;
    end else begin
      proceed_q <= acc_evt;
      if (acc_evt)
        fetch_q <= 1'b1;
      else if (scoreboard_issue_in)
        fetch_q <= 1'b0;
    end
  end

  assign proceed_out    = proceed_q;
  assign fetch_flag_out = fetch_q;

  ////////////////////////////////////////////////////////////////////////
  // stop flag and program address clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_q <= 1'b0;
    end else if ((error_q && state_q == abx_pkg::ABX_ST_IDLE) || halt_hit || nstop_hit) begin
      stop_q <= 1'b1;
    end else if (acc_evt || (wr_en && avs_address_in == `ABX_OFS_CLEAR &&
                             avs_writedata_in[`ABX_CLR_STOP])) begin
      stop_q <= 1'b0;
    end
  end

  // clear program address on stop code
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pclr_q <= 1'b0;
    end else begin
      pclr_q <= nstop_hit;
    end
  end

  assign stop_out    = stop_q;
  assign p_clear_out = pclr_q;
endmodule : abx_exit_stop

// >>> hdl/abx_defs.svh
// offsets, tags, field positions and timing figures of the bounds/exit-stop block
`ifndef ABX_DEFS_SVH
`define ABX_DEFS_SVH
// register word offsets on the avalon slave
`define ABX_OFS_LIMIT    4'h0
`define ABX_OFS_BASE     4'h1
`define ABX_OFS_EXITSEL  4'h2
`define ABX_OFS_STATUS   4'h3
`define ABX_OFS_CLEAR    4'h4
// exit selection bit positions
`define ABX_EM_OOB       0
`define ABX_EM_INF       1
`define ABX_EM_INDEF     2
// clear register bit positions
`define ABX_CLR_OOB      0
`define ABX_CLR_STOP     1
// queue tags (octal 10, 50, 1n, 5n) and write bit
`define ABX_TAG_RNI      6'h08
`define ABX_TAG_XWRITE   6'h28
`define ABX_TAG_READ     6'h08
`define ABX_TAG_STORE    6'h28
`define ABX_TAG_WBIT     5
// floating exponent limit, octal 3777
`define ABX_EXP_MAX      12'h7FF
// timing figures in ns and clock rate in MHz
`define ABX_DELAY_NS     200
`define ABX_GAP_NS       300
`define ABX_CLK_MHZ      250
`endif

// >>> hdl/abx_pkg.sv
// types shared by the bounds/exit-stop block
package abx_pkg;
  typedef enum logic [2:0] {
    ABX_ST_IDLE  = 3'b000,
    ABX_ST_DELAY = 3'b001,
    ABX_ST_WRITE = 3'b010,
    ABX_ST_GAP   = 3'b011,
    ABX_ST_FETCH = 3'b100,
    ABX_ST_HALT  = 3'b101
  } abx_state_t;
  typedef enum logic [1:0] {
    ABX_K_FETCH = 2'b00,
    ABX_K_READ  = 2'b01,
    ABX_K_STORE = 2'b10
  } abx_kind_t;
endpackage : abx_pkg

// >>> hdl/abx_cmp_if.sv
// carrier between the exit-stop top and its bounds comparator
interface abx_cmp_if #(parameter int ADDR_W = 18);
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] limit;
  logic              beyond;
  modport cmp  (input addr, input limit, output beyond);
  modport user (output addr, output limit, input beyond);
endinterface : abx_cmp_if

// >>> hdl/abx_bound_cmp.sv
// staging address against field length limit, grouped bit and octal digit compare
module abx_bound_cmp #(
  parameter int ADDR_W = 18
) (
  // comparison carrier
  abx_cmp_if.cmp c
);
  localparam int ND = ADDR_W / 3;

  logic [ND-1:0] grp_ge;
  logic [ND-1:0] dig_gt;
  logic [ND-1:0] dig_eq;
  logic [ND:0]   win;
  logic [ND:0]   hi_eq;

  // refuse widths that do not split into whole octal digits
  if (ADDR_W % 3 != 0 || ADDR_W < 3) begin : g_bad_width
    $error("ADDR_W must be a positive multiple of 3");
  end

  // per-digit compares and ripple from the top digit down
  assign win[ND]   = 1'b0;
  assign hi_eq[ND] = 1'b1;
  for (genvar d = 0; d < ND; d++) begin : g_dig
    assign grp_ge[d] = &(c.addr[3*d +: 3] | ~c.limit[3*d +: 3]);
    assign dig_gt[d] = c.addr[3*d +: 3] > c.limit[3*d +: 3];
    assign dig_eq[d] = grp_ge[d] & ~dig_gt[d];
    assign win[d]    = win[d+1] | (hi_eq[d+1] & dig_gt[d]);
    assign hi_eq[d]  = hi_eq[d+1] & dig_eq[d];
  end

  assign c.beyond = win[0] | hi_eq[0];
endmodule : abx_bound_cmp

// >>> dv/abx_queue_model.sv
// far-side queue model: takes entries and answers with accept and tag
module abx_queue_model (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  // pacing and queue entry
  input  wire logic       slow_in,
  input  wire logic       q_valid_in,
  input  wire logic [5:0] q_tag_in,
  // answers to the block
  output logic            q_ready_out,
  output logic            accept_out,
  output logic [5:0]      acc_tag_out
);
  logic       ph_q;
  logic [5:0] tag_q;
  // slow mode takes an entry only every other cycle
  assign q_ready_out = q_valid_in && (!slow_in || ph_q);
  // tag lines show garbage outside an accept pulse
  assign acc_tag_out = accept_out ? tag_q : ~tag_q;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_q       <= 1'b0;
      accept_out <= 1'b0;
      tag_q      <= 6'h00;
    end else begin
      ph_q       <= !ph_q;
      accept_out <= q_ready_out;
      if (q_ready_out) begin
        tag_q <= q_tag_in;
      end
    end
  end
endmodule : abx_queue_model

// >>> dv/abx_exit_stop_checker.sv
// port assertions of the bounds/exit-stop top
module abx_exit_stop_chk #(
  parameter int ADDR_W = 18
) (
  input wire logic              ref_clk_in,
  input wire logic              rstn_in,
  input wire logic [3:0]        avs_address_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_writedata_in,
  input wire logic              avs_waitrequest_out,
  input wire logic              stg_valid_in,
  input wire logic [ADDR_W-1:0] stg_addr_in,
  input wire logic [1:0]        stg_kind_in,
  input wire logic [2:0]        stg_reg_in,
  input wire logic              stg_ready_out,
  input wire logic              q_valid_out,
  input wire logic [ADDR_W-1:0] q_addr_out,
  input wire logic [5:0]        q_tag_out,
  input wire logic              q_ready_in,
  input wire logic              mem_accept_in,
  input wire logic [5:0]        acc_tag_in,
  input wire logic              scoreboard_issue_in,
  input wire logic [5:0]        fcode_in,
  input wire logic              proceed_out,
  input wire logic              fetch_flag_out,
  input wire logic              stop_out,
  input wire logic              p_clear_out,
  input wire logic              go_branch_out,
  input wire logic              fp_valid_in,
  input wire logic [11:0]       fp_exp_in
);
  logic [ADDR_W-1:0] lim_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] reloc;
  logic [2:0]        sel_q;
  logic              take;
  logic              oob;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // shadow of limit, base and exit selection
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lim_q  <= '0;
      base_q <= '0;
      sel_q  <= 3'h0;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in == 4'h0) lim_q <= avs_writedata_in[ADDR_W-1:0];
      if (avs_address_in == 4'h1) base_q <= avs_writedata_in[ADDR_W-1:0];
      if (avs_address_in == 4'h2) sel_q <= avs_writedata_in[2:0];
    end
  end
  // staging take and bound decision
  assign take  = stg_valid_in && stg_ready_out;
  assign oob   = stg_addr_in >= lim_q;
  assign reloc = stg_addr_in + base_q;
  AST_FETCH_OOB: assert property (take && oob && stg_kind_in == 2'h0 |=>
    q_valid_out && q_addr_out == '0 && q_tag_out == 6'h08) else $error("oob fetch entry wrong");
  AST_READ_OOB: assert property (take && oob && stg_kind_in == 2'h1 |=>
    q_valid_out && q_addr_out == '0 && q_tag_out == 6'h08) else $error("oob read entry wrong");
  AST_STORE_OOB: assert property (take && oob && stg_kind_in == 2'h2 |=>
    q_addr_out == '0 && q_tag_out == {3'h1, $past(stg_reg_in)}) else $error("oob store entry wrong");
  AST_NO_WBIT: assert property (take && oob |=> !q_tag_out[5]) else $error("write bit on oob");
  AST_RELOC: assert property (take && !oob |=> q_addr_out == $past(reloc)) else $error("bad relocation");
  AST_PROCEED: assert property (mem_accept_in && acc_tag_in == 6'h08 && sel_q[0] |=>
    proceed_out && fetch_flag_out) else $error("no proceed after accept");
  AST_STOP_CODE: assert property (scoreboard_issue_in && fcode_in == 6'h00 |=>
    stop_out && p_clear_out) else $error("stop code ignored");
  AST_FP_ERR: assert property (fp_valid_in && fp_exp_in > 12'h7FF && sel_q[1] && !stop_out
    && !go_branch_out |-> ##[2:3] stop_out) else $error("infinite did not stop");
  AST_EXIT_REC: assert property ($rose(go_branch_out) |-> q_valid_out
    && q_tag_out == 6'h28 && q_addr_out == base_q) else $error("exit record entry wrong");
  AST_GAP: assert property (q_valid_out && q_ready_in && q_tag_out == 6'h28 |->
    ##[60:120] (q_valid_out && q_tag_out == 6'h08 && q_addr_out == base_q)) else $error("no refetch");
  // main scenarios reached
  cover property ($rose(go_branch_out));
  cover property (proceed_out);
  cover property (p_clear_out);
endmodule : abx_exit_stop_chk

bind abx_exit_stop abx_exit_stop_chk #(.ADDR_W(ADDR_W)) chk_u (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out), .stg_valid_in(stg_valid_in),
  .stg_addr_in(stg_addr_in), .stg_kind_in(stg_kind_in), .stg_reg_in(stg_reg_in), .stg_ready_out(stg_ready_out),
  .q_valid_out(q_valid_out), .q_addr_out(q_addr_out), .q_tag_out(q_tag_out), .q_ready_in(q_ready_in),
  .mem_accept_in(mem_accept_in), .acc_tag_in(acc_tag_in), .scoreboard_issue_in(scoreboard_issue_in), .fcode_in(fcode_in),
  .proceed_out(proceed_out), .fetch_flag_out(fetch_flag_out), .stop_out(stop_out), .p_clear_out(p_clear_out),
  .go_branch_out(go_branch_out), .fp_valid_in(fp_valid_in), .fp_exp_in(fp_exp_in));

// >>> dv/abx_exit_stop_tb_top.sv
// self-checking bench of the bounds/exit-stop block
module abx_exit_stop_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] kind; logic [2:0] rg; logic [17:0] a; logic [17:0] ea; logic [5:0] et;} abx_row_t;
  logic        ref_clk_in = 1'b0, rstn_in = 1'b0, slow = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
  logic        stg_valid_in = 1'b0, exch_in = 1'b0, stg_ready_out;
  logic [17:0] stg_addr_in = 18'h0, prog_addr_in = 18'h00123, q_addr_out;
  logic [1:0]  stg_kind_in = 2'h0;
  logic [2:0]  stg_reg_in = 3'h0;
  logic        q_valid_out, q_ready_in, mem_accept_in;
  logic [5:0]  q_tag_out, acc_tag_in, fcode_in = 6'h3F;
  logic [59:0] q_data_out;
  logic        error_sync_in = 1'b0, inch_in = 1'b0, scoreboard_issue_in = 1'b0, fp_valid_in = 1'b0, fp_indef_in = 1'b0;
  logic [11:0] fp_exp_in = 12'h000;
  logic        proceed_out, fetch_flag_out, stop_out, p_clear_out, go_branch_out;
  int          fails = 0, cmp_count = 0, cyc = 0, n;
  // limit 01000, base 02000: in-bounds then out-of-bounds cases
  abx_row_t rows [7] = '{'{2'h0, 3'h0, 18'h00010, 18'h02010, 6'h08}, '{2'h1, 3'h3, 18'h00FFF, 18'h02FFF, 6'h0B},
    '{2'h2, 3'h6, 18'h00E00, 18'h02E00, 6'h2E}, '{2'h0, 3'h0, 18'h01000, 18'h0, 6'h08},
    '{2'h1, 3'h2, 18'h3FFFF, 18'h0, 6'h08}, '{2'h2, 3'h6, 18'h01800, 18'h0, 6'h0E},
    '{2'h2, 3'h7, 18'h01000, 18'h0, 6'h0F}};
  abx_exit_stop dut_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .stg_valid_in(stg_valid_in),
    .stg_addr_in(stg_addr_in), .stg_kind_in(stg_kind_in), .stg_reg_in(stg_reg_in), .prog_addr_in(prog_addr_in),
    .exch_in(exch_in), .stg_ready_out(stg_ready_out), .q_valid_out(q_valid_out), .q_addr_out(q_addr_out),
    .q_tag_out(q_tag_out), .q_data_out(q_data_out), .q_ready_in(q_ready_in), .mem_accept_in(mem_accept_in),
    .acc_tag_in(acc_tag_in), .error_sync_in(error_sync_in), .inch_in(inch_in), .scoreboard_issue_in(scoreboard_issue_in),
    .fcode_in(fcode_in), .proceed_out(proceed_out), .fetch_flag_out(fetch_flag_out), .stop_out(stop_out),
    .p_clear_out(p_clear_out), .go_branch_out(go_branch_out), .fp_valid_in(fp_valid_in), .fp_exp_in(fp_exp_in),
    .fp_indef_in(fp_indef_in));
  abx_queue_model far_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .slow_in(slow), .q_valid_in(q_valid_out),
    .q_tag_in(q_tag_out), .q_ready_out(q_ready_in), .accept_out(mem_accept_in), .acc_tag_out(acc_tag_in));
  // clock and hang guard
  always #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  task check(input logic [59:0] seen, input logic [59:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // one avalon cycle, held until waitrequest is seen low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    if (wr) avs_write_in <= 1'b1;
    else avs_read_in <= 1'b1;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : av
  // one staging request and its queue entry
  task stg(input abx_row_t r);
    @(posedge ref_clk_in);
    stg_kind_in <= r.kind;
    stg_reg_in <= r.rg;
    stg_addr_in <= r.a;
    stg_valid_in <= 1'b1;
    do @(posedge ref_clk_in); while (stg_ready_out !== 1'b1);
    stg_valid_in <= 1'b0;
    #1;
    check(q_valid_out, 1);
    check(q_addr_out, r.ea);
    check(q_tag_out, r.et);
  endtask : stg
  // exit record, jump, refetch and halt
  task seq_tail(input logic [2:0] c);
    n = 0;
    while (go_branch_out !== 1'b1 && n < 300) begin
      @(posedge ref_clk_in);
      n++;
    end
    #1;
    check(q_tag_out, 6'h28);
    check(q_addr_out, 18'h02000);
    check(q_data_out, {9'h000, c, 18'h00123, 30'h0});
    n = 0;
    while (!(q_valid_out === 1'b1 && q_tag_out === 6'h08) && n < 300) begin
      @(posedge ref_clk_in);
      n++;
    end
    check(n >= 70 && n <= 85, 1);
    check(q_addr_out, 18'h02000);
    repeat (6) @(posedge ref_clk_in);
    scoreboard_issue_in <= 1'b1;
    fcode_in <= 6'h07;
    @(posedge ref_clk_in);
    scoreboard_issue_in <= 1'b0;
    fcode_in <= 6'h3F;
    #1;
    check(stop_out, 1);
  endtask : seq_tail
  // floating fault pulse, then settle
  task fp(input logic [11:0] e, input logic ind);
    @(posedge ref_clk_in);
    fp_valid_in <= 1'b1;
    fp_exp_in <= e;
    fp_indef_in <= ind;
    @(posedge ref_clk_in);
    fp_valid_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : fp
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    av(0, 4'h3, 0);
    check(rd, 0);
    av(0, 4'hF, 0);
    check(rd, 0);
    av(1, 4'h0, 32'h01000);
    av(1, 4'h1, 32'h02000);
    av(1, 4'h2, 0);
    error_sync_in <= 1'b1;
    for (int i = 0; i < 7; i++) stg(rows[i]);
    $display("bounds rows test done");
    repeat (4) @(posedge ref_clk_in);
    check(stop_out, 0);
    av(0, 4'h3, 0);
    check(rd[2:0], 3'h1);
    av(1, 4'h4, 1);
    exch_in <= 1'b1;
    stg(rows[3]);
    exch_in <= 1'b0;
    av(0, 4'h3, 0);
    check(rd[0], 0);
    $display("flag test done");
    slow <= 1'b1;
    inch_in <= 1'b1;
    av(1, 4'h2, 1);
    stg('{2'h0, 3'h0, 18'h01234, 18'h0, 6'h08});
    repeat (60) @(posedge ref_clk_in);
    check(go_branch_out, 0);
    inch_in <= 1'b0;
    seq_tail(3'h1);
    $display("exit stop test done");
    @(posedge ref_clk_in);
    scoreboard_issue_in <= 1'b1;
    fcode_in <= 6'h00;
    @(posedge ref_clk_in);
    scoreboard_issue_in <= 1'b0;
    #1;
    check({p_clear_out, stop_out}, 2'h3);
    @(posedge ref_clk_in);
    #1;
    check(p_clear_out, 0);
    av(1, 4'h4, 2);
    av(1, 4'h2, 2);
    fp(12'h7FF, 1'b1);
    check(stop_out, 0);
    for (int k = 1; k < 3; k++) begin
      av(1, 4'h4, 2);
      av(1, 4'h2, 32'h1 << k);
      fp(k == 1 ? 12'h800 : 12'h000, k == 2);
      check(stop_out, 1);
      seq_tail(3'(1 << k));
    end
    $display("floating fault test done");
    test_done();
  end
endmodule : abx_exit_stop_tb_top
